//--- msb_sfr_bank.sv
`timescale 1ns/1ps
module msb_sfr_bank (
    input  wire logic                        mclk_i,
    input  wire logic                        srst_i,
    input  wire logic [7:0]                  sfr_addr_i,
    input  wire logic                        sfr_wr_i,
    input  wire logic                        sfr_rd_i,
    input  wire logic [7:0]                  sfr_wdata_i,
    output logic      [7:0]                  sfr_rdata_o,
    input  wire logic [3:0]                  std_irq_flag_i,
    input  wire logic [msb_pkg::NUM_EXT-1:0] ext_irq_pulse_i,
    input  wire logic [7:0]                  port0_irq_mask_i,
    input  wire logic [7:0]                  port1_irq_mask_i,
    input  wire logic                        irq_ack_i,
    input  wire logic                        irq_reti_i,
    output logic                             irq_req_o,
    output logic      [msb_pkg::ID_W-1:0]    irq_id_o,
    input  wire logic                        rxd_i,
    output logic                             txd_o,
    output logic                             shift_clk_o,
    output logic      [1:0]                  reg_bank_o
);
    import msb_pkg::*;

    msb_irq_if irq ();

    logic [1:0]         sc_mode_ff;
    logic               sc_rx_en_ff;
    logic               sc_tx9_ff;
    logic               sc_rx9_ff;
    logic               tx_done_ff;
    logic               rx_done_ff;
    logic [7:0]         rx_data_ff;
    logic [7:0]         baud_high_ff;
    logic [7:0]         baud_low_ff;
    logic [1:0]         sync_div_ff;
    logic [7:0]         port_two_ff;
    logic [7:0]         irq_enable_ff;
    logic [7:0]         port3_mask_ff;
    logic [4:0]         irq_prio_ff;
    logic [7:0]         status_word_ff;
    logic [7:0]         main_operand_ff;
    logic [7:0]         muldiv_operand_ff;
    logic [NUM_EXT-1:0] ext_flag_ff;
    logic [NUM_EXT-1:0] ext_pulse_q_ff;
    logic [7:0]         rdata_ff;
    logic [15:0]        baud_cnt_ff;
    logic [3:0]         div_cnt_ff;
    logic               shift_clk_ff;
    logic               tx_busy_ff;
    logic [3:0]         tx_left_ff;
    logic [10:0]        tx_shift_ff;
    logic               txd_ff;
    logic               rx_busy_ff;
    logic [3:0]         rx_left_ff;
    logic [10:0]        rx_shift_ff;
    logic               rxd_q_ff;

    logic               wr_sc;
    logic               wr_data;
    logic [15:0]        baud_reload;
    logic               baud_tick;
    logic [3:0]         div_term;
    logic               div_tick;
    logic               bit_tick;
    logic               tx_set;
    logic               rx_set;
    logic [10:0]        nxt_rx_shift;
    logic [7:0]         rx_byte;
    logic               rx_ninth;
    logic [NUM_EXT-1:0] ext_set;
    logic [NUM_EXT-1:0] ext_clr;
    logic [NUM_EXT-1:0] ext_mask;
    logic [2:0]         ext_wr;
    logic [NUM_STD-1:0] std_req;
    logic               gate;

    assign wr_sc   = sfr_wr_i && sfr_addr_i == ADR_SERIAL_CONTROL;
    assign wr_data = sfr_wr_i && sfr_addr_i == ADR_SERIAL_DATA;

    // serial control: mode, receive enable, ninth bits
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sc_mode_ff  <= SC_RESET[SC_MODE_LSB+1:SC_MODE_LSB];
            sc_rx_en_ff <= SC_RESET[SC_RX_EN];
            sc_tx9_ff   <= SC_RESET[SC_TX9];
            sc_rx9_ff   <= SC_RESET[SC_RX9];
        end else begin
            if (wr_sc) begin
                sc_mode_ff  <= sfr_wdata_i[SC_MODE_LSB+1:SC_MODE_LSB];
                sc_rx_en_ff <= sfr_wdata_i[SC_RX_EN];
                sc_tx9_ff   <= sfr_wdata_i[SC_TX9];
            end
            // a frame landing in the write cycle keeps its ninth bit
            if (rx_set) begin
                sc_rx9_ff <= rx_ninth;
            end else if (wr_sc) begin
                sc_rx9_ff <= sfr_wdata_i[SC_RX9];
            end
        end
    end

    // done flags: set beats a write-zero clear, writing one has no effect
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            tx_done_ff <= SC_RESET[SC_TX_DONE];
            rx_done_ff <= SC_RESET[SC_RX_DONE];
        end else begin
            tx_done_ff <= tx_set || (tx_done_ff && !(wr_sc && !sfr_wdata_i[SC_TX_DONE]));
            rx_done_ff <= rx_set || (rx_done_ff && !(wr_sc && !sfr_wdata_i[SC_RX_DONE]));
        end
    end

    // plain byte registers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            baud_high_ff      <= REG_RESET;
            baud_low_ff       <= REG_RESET;
            sync_div_ff       <= REG_RESET[1:0];
            port_two_ff       <= REG_RESET;
            irq_enable_ff     <= REG_RESET;
            port3_mask_ff     <= REG_RESET;
            irq_prio_ff       <= REG_RESET[4:0];
            status_word_ff    <= REG_RESET;
            main_operand_ff   <= REG_RESET;
            muldiv_operand_ff <= REG_RESET;
        end else if (sfr_wr_i) begin
            unique case (sfr_addr_i)
                ADR_BAUD_HIGH:    baud_high_ff      <= sfr_wdata_i;
                ADR_BAUD_LOW:     baud_low_ff       <= sfr_wdata_i;
                ADR_SYNC_DIV:     sync_div_ff       <= sfr_wdata_i[1:0];
                ADR_PORT_TWO:     port_two_ff       <= sfr_wdata_i;
                ADR_IRQ_ENABLE:   irq_enable_ff     <= sfr_wdata_i & IE_MASK;
                ADR_PORT3_MASK:   port3_mask_ff     <= sfr_wdata_i;
                ADR_IRQ_PRIO:     irq_prio_ff       <= sfr_wdata_i[4:0];
                ADR_STATUS_WORD:  status_word_ff    <= sfr_wdata_i;
                ADR_MAIN_OPERAND: main_operand_ff   <= sfr_wdata_i;
                ADR_MULDIV:       muldiv_operand_ff <= sfr_wdata_i;
                default: ;
            endcase
        end
    end

    // bit timing: reload count in variable modes, divider in shift mode
    assign baud_reload = {baud_high_ff, baud_low_ff};
    assign baud_tick   = baud_cnt_ff >= baud_reload;
    assign div_term    = 4'((5'h02 << sync_div_ff) - 5'h01);
    assign div_tick    = div_cnt_ff >= div_term;
    assign bit_tick    = (sc_mode_ff == MODE_SHIFT) ? div_tick : baud_tick;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            baud_cnt_ff <= 16'h0000;
            div_cnt_ff  <= 4'h0;
        end else begin
            baud_cnt_ff <= baud_tick ? 16'h0000 : baud_cnt_ff + 16'h0001;
            div_cnt_ff  <= div_tick ? 4'h0 : div_cnt_ff + 4'h1;
        end
    end

    // shift clock low in the first half of each bit, high when idle
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            shift_clk_ff <= 1'b1;
        end else begin
            // inclusive compare keeps one low cycle at divide by two
            shift_clk_ff <= !(tx_busy_ff && sc_mode_ff == MODE_SHIFT && div_cnt_ff <= (div_term >> 1));
        end
    end

    // transmitter; a write while busy is dropped, firmware waits for the flag
    assign tx_set = tx_busy_ff && bit_tick && tx_left_ff == 4'h0;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            tx_busy_ff  <= 1'b0;
            tx_left_ff  <= 4'h0;
            tx_shift_ff <= 11'h7FF;
            txd_ff      <= 1'b1;
        end else if (wr_data && !tx_busy_ff) begin
            tx_busy_ff <= 1'b1;
            unique case (sc_mode_ff)
                MODE_SHIFT: begin
                    tx_shift_ff <= {3'h7, sfr_wdata_i};
                    tx_left_ff  <= BITS_SHIFT;
                end
                MODE_UART8: begin
                    tx_shift_ff <= {2'h3, sfr_wdata_i, 1'b0};
                    tx_left_ff  <= BITS_UART8;
                end
                default: begin
                    tx_shift_ff <= {1'b1, sc_tx9_ff, sfr_wdata_i, 1'b0};
                    tx_left_ff  <= BITS_UART9;
                end
            endcase
        end else if (tx_busy_ff && bit_tick) begin
            if (tx_left_ff != 4'h0) begin
                txd_ff      <= tx_shift_ff[0];
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                tx_left_ff  <= tx_left_ff - 4'h1;
            end else begin
                tx_busy_ff <= 1'b0;
                txd_ff     <= 1'b1;
            end
        end
    end

    // receiver, variable-rate modes only; shift-mode reception not supported
    assign nxt_rx_shift = {rxd_i, rx_shift_ff[10:1]};
    assign rx_byte      = (sc_mode_ff == MODE_UART8) ? nxt_rx_shift[9:2] : nxt_rx_shift[8:1];
    assign rx_ninth     = (sc_mode_ff == MODE_UART8) ? nxt_rx_shift[10] : nxt_rx_shift[9];
    assign rx_set       = rx_busy_ff && bit_tick && rx_left_ff == 4'h1 && sc_rx_en_ff;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rxd_q_ff    <= 1'b1;
            rx_busy_ff  <= 1'b0;
            rx_left_ff  <= 4'h0;
            rx_shift_ff <= 11'h000;
            rx_data_ff  <= REG_RESET;
        end else begin
            rxd_q_ff <= rxd_i;
            if (!rx_busy_ff) begin
                if (sc_rx_en_ff && sc_mode_ff != MODE_SHIFT && rxd_q_ff && !rxd_i) begin
                    rx_busy_ff <= 1'b1;
                    rx_left_ff <= (sc_mode_ff == MODE_UART8) ? BITS_UART8 : BITS_UART9;
                end
            end else if (!sc_rx_en_ff) begin
                rx_busy_ff <= 1'b0;
            end else if (bit_tick) begin
                rx_shift_ff <= nxt_rx_shift;
                rx_left_ff  <= rx_left_ff - 4'h1;
                if (rx_left_ff == 4'h1) begin
                    rx_busy_ff <= 1'b0;
                    rx_data_ff <= rx_byte;
                end
            end
        end
    end

    // extended flags: rising one-clock pulses set, service end or entry clears
    assign ext_mask = {port3_mask_ff, port1_irq_mask_i, port0_irq_mask_i};
    assign ext_wr   = {sfr_wr_i && sfr_addr_i == ADR_PORT3_FLAGS,
                       sfr_wr_i && sfr_addr_i == ADR_PORT1_FLAGS,
                       sfr_wr_i && sfr_addr_i == ADR_PORT0_FLAGS};

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ext_pulse_q_ff <= '0;
        end else begin
            ext_pulse_q_ff <= ext_irq_pulse_i;
        end
    end

    for (genvar g = 0; g < NUM_EXT; g++) begin : g_ext
        localparam logic [ID_W-1:0] SRC_ID = ID_W'(g + NUM_STD);
        assign ext_set[g] = ext_irq_pulse_i[g] && !ext_pulse_q_ff[g];
        // trigger mode drops the flag on entry, pending mode holds it to the return
        assign ext_clr[g] = (irq.grant_id == SRC_ID) &&
                            (irq_enable_ff[IE_PEND] ? (irq.in_service && irq_reti_i)
                                                    : (irq.grant_valid && irq_ack_i));
        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                ext_flag_ff[g] <= 1'b0;
            end else if (ext_set[g]) begin
                ext_flag_ff[g] <= 1'b1;
            end else if (ext_clr[g]) begin
                ext_flag_ff[g] <= 1'b0;
            end else if (ext_wr[g / 8]) begin
                ext_flag_ff[g] <= sfr_wdata_i[g % 8];
            end
        end
    end

    // requests to the arbiter
    assign gate    = irq_enable_ff[IE_GLOBAL];
    assign std_req = {tx_done_ff || rx_done_ff, std_irq_flag_i} & irq_enable_ff[4:0];
    assign irq.req     = {ext_flag_ff & ext_mask, std_req} & {NUM_SRC{gate}};
    assign irq.hi_prio = irq_prio_ff;
    assign irq.ack     = irq_ack_i;
    assign irq.reti    = irq_reti_i;

    msb_irq_arb u_arb (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .irq    (irq)
    );

    // registered read data, unmapped addresses read zero
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_ff <= 8'h00;
        end else if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                ADR_SERIAL_CONTROL: rdata_ff <= {sc_mode_ff, 1'b0, sc_rx_en_ff, sc_tx9_ff, sc_rx9_ff,
                                                 tx_done_ff, rx_done_ff} & SC_MASK;
                ADR_SERIAL_DATA:    rdata_ff <= rx_data_ff;
                ADR_BAUD_HIGH:      rdata_ff <= baud_high_ff;
                ADR_BAUD_LOW:       rdata_ff <= baud_low_ff;
                ADR_SYNC_DIV:       rdata_ff <= {6'h00, sync_div_ff} & DIV_MASK;
                ADR_PORT_TWO:       rdata_ff <= port_two_ff;
                ADR_IRQ_ENABLE:     rdata_ff <= irq_enable_ff;
                ADR_PORT3_MASK:     rdata_ff <= port3_mask_ff;
                ADR_IRQ_PRIO:       rdata_ff <= {3'h0, irq_prio_ff} & IP_MASK;
                ADR_STATUS_WORD:    rdata_ff <= status_word_ff;
                ADR_PORT0_FLAGS:    rdata_ff <= ext_flag_ff[7:0];
                ADR_MAIN_OPERAND:   rdata_ff <= main_operand_ff;
                ADR_PORT1_FLAGS:    rdata_ff <= ext_flag_ff[15:8];
                ADR_MULDIV:         rdata_ff <= muldiv_operand_ff;
                ADR_PORT3_FLAGS:    rdata_ff <= ext_flag_ff[23:16];
                default:            rdata_ff <= 8'h00;
            endcase
        end
    end

    assign sfr_rdata_o = rdata_ff;
    assign irq_req_o   = irq.grant_valid;
    assign irq_id_o    = irq.grant_id;
    assign txd_o       = txd_ff;
    assign shift_clk_o = shift_clk_ff;
    assign reg_bank_o  = status_word_ff[PSW_BANK_LSB+1:PSW_BANK_LSB];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    a_rx_gate_idle: assert property (!sc_rx_en_ff |=> !rx_busy_ff && !$rose(rx_done_ff))
        else $error("receiver active while disabled");
    a_tx_ninth_load: assert property ((wr_data && !tx_busy_ff && sc_mode_ff[1])
        |=> tx_shift_ff[9] == $past(sc_tx9_ff) && tx_left_ff == BITS_UART9)
        else $error("ninth transmit bit not loaded");
    a_done_wr_clear: assert property ((wr_sc && !sfr_wdata_i[SC_TX_DONE] && !tx_set) |=> !tx_done_ff)
        else $error("transmit flag not cleared by zero write");
    a_done_set_wins: assert property (rx_set |=> rx_done_ff && rx_data_ff == $past(rx_byte))
        else $error("receive completion lost");
    a_baud_restart: assert property (baud_tick |=> baud_cnt_ff == 16'h0000)
        else $error("baud counter did not restart");
    a_div_sixteen: assert property ((div_tick && sync_div_ff == 2'h3)
        |=> (!div_tick || sync_div_ff != 2'h3) [*8])
        else $error("divide by sixteen too short");
    a_global_block: assert property (!irq_enable_ff[IE_GLOBAL] |=> !irq_req_o)
        else $error("request with global enable off");
    a_ext_pulse_set: assert property ((|ext_set) |=> (ext_flag_ff & $past(ext_set)) == $past(ext_set))
        else $error("extended flag not set by pulse");
    a_div_rsv_zero: assert property ((sfr_rd_i && sfr_addr_i == ADR_SYNC_DIV) |=> sfr_rdata_o[7:2] == 6'h00)
        else $error("reserved divider bits not zero");
endmodule // msb_sfr_bank

//--- msb_pkg.sv
// What this block does
// - receive accepted only while rx_enable set
// - ninth transmitted bit in 9-bit modes
// - ninth received bit captured, firmware writable
// - done flags at bits 1/0, write-zero clears
// - 16-bit baud count split high/low bytes
// - shift mode clock divides by 2/4/8/16
// - global enable blocks every interrupt
// - pending mode keeps extended flags till return
// - individual enables for five standard sources
// - port 3 mask enables each of the eight port 3 extended inputs
// - priority bits raise standard sources high
// - status word flags and bank select
// - three extended flag registers reset zero
// - operand register for multiply and divide
// - flags set by one-clock rising pulse
// - fixed priority service, never nested
// - mode field picks shift, 8-bit, 9-bit
package msb_pkg;
    localparam logic [7:0] ADR_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] ADR_SERIAL_DATA    = 8'h99;
    localparam logic [7:0] ADR_BAUD_HIGH      = 8'h9A;
    localparam logic [7:0] ADR_BAUD_LOW       = 8'h9B;
    localparam logic [7:0] ADR_SYNC_DIV       = 8'h9C;
    localparam logic [7:0] ADR_PORT_TWO       = 8'hA0;
    localparam logic [7:0] ADR_IRQ_ENABLE     = 8'hA8;
    localparam logic [7:0] ADR_PORT3_MASK     = 8'hB0;
    localparam logic [7:0] ADR_IRQ_PRIO       = 8'hB8;
    localparam logic [7:0] ADR_STATUS_WORD    = 8'hD0;
    localparam logic [7:0] ADR_PORT0_FLAGS    = 8'hD8;
    localparam logic [7:0] ADR_MAIN_OPERAND   = 8'hE0;
    localparam logic [7:0] ADR_PORT1_FLAGS    = 8'hE8;
    localparam logic [7:0] ADR_MULDIV         = 8'hF0;
    localparam logic [7:0] ADR_PORT3_FLAGS    = 8'hF8;
    localparam int SC_MODE_LSB  = 6;
    localparam int SC_RX_EN     = 4;
    localparam int SC_TX9       = 3;
    localparam int SC_RX9       = 2;
    localparam int SC_TX_DONE   = 1;
    localparam int SC_RX_DONE   = 0;
    localparam int IE_GLOBAL    = 7;
    localparam int IE_PEND      = 6;
    localparam int PSW_BANK_LSB = 3;
    localparam logic [7:0] SC_RESET   = 8'h50;
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [7:0] SC_MASK    = 8'hDF;
    localparam logic [7:0] IE_MASK    = 8'hDF;
    localparam logic [7:0] IP_MASK    = 8'h1F;
    localparam logic [7:0] DIV_MASK   = 8'h03;
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [3:0] BITS_SHIFT = 4'h8;
    localparam logic [3:0] BITS_UART8 = 4'hA;
    localparam logic [3:0] BITS_UART9 = 4'hB;
    localparam int NUM_STD = 5;
    localparam int NUM_EXT = 24;
    localparam int NUM_SRC = 29;
    localparam int ID_W    = 5;
endpackage

//--- msb_irq_if.sv
`timescale 1ns/1ps
interface msb_irq_if;
    logic [28:0] req;
    logic [4:0]  hi_prio;
    logic        ack;
    logic        reti;
    logic        grant_valid;
    logic [4:0]  grant_id;
    logic        in_service;
    modport bank (output req, hi_prio, ack, reti, input grant_valid, grant_id, in_service);
    modport arb  (input req, hi_prio, ack, reti, output grant_valid, grant_id, in_service);
endinterface

//--- msb_irq_arb.sv
`timescale 1ns/1ps
module msb_irq_arb (
    input  wire logic mclk_i,
    input  wire logic srst_i,
    msb_irq_if.arb    irq
);
    import msb_pkg::*;

    typedef enum logic [1:0] {ARB_IDLE, ARB_OFFER, ARB_SERVE} msb_arb_state_t;

    msb_arb_state_t   state_ff;
    logic             grant_valid_ff;
    logic [ID_W-1:0]  grant_id_ff;
    logic             pick_valid;
    logic [ID_W-1:0]  pick_id;

    // lowest index wins; high-priority standard sources override
    always_comb begin
        pick_valid = 1'b0;
        pick_id    = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (irq.req[i]) begin
                pick_valid = 1'b1;
                pick_id    = ID_W'(i);
            end
        end
        for (int i = NUM_STD - 1; i >= 0; i--) begin
            if (irq.req[i] && irq.hi_prio[i]) begin
                pick_valid = 1'b1;
                pick_id    = ID_W'(i);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_ff       <= ARB_IDLE;
            grant_valid_ff <= 1'b0;
            grant_id_ff    <= '0;
        end else begin
            unique case (state_ff)
                ARB_IDLE: begin
                    if (pick_valid) begin
                        state_ff       <= ARB_OFFER;
                        grant_valid_ff <= 1'b1;
                        grant_id_ff    <= pick_id;
                    end
                end
                ARB_OFFER: begin
                    if (irq.ack) begin
                        state_ff       <= ARB_SERVE;
                        grant_valid_ff <= 1'b0;
                    end else if (!irq.req[grant_id_ff]) begin
                        state_ff       <= ARB_IDLE;
                        grant_valid_ff <= 1'b0;
                    end
                end
                ARB_SERVE: begin
                    // no preemption: nothing offered until the return
                    if (irq.reti) begin
                        state_ff <= ARB_IDLE;
                    end
                end
            endcase
        end
    end

    assign irq.grant_valid = grant_valid_ff;
    assign irq.grant_id    = grant_id_ff;
    assign irq.in_service  = (state_ff == ARB_SERVE);

    a_no_nesting: assert property (@(posedge mclk_i) disable iff (srst_i)
        (state_ff == ARB_SERVE && !irq.reti) |=> !grant_valid_ff)
        else $error("interrupt offered during service");
    a_pick_latched: assert property (@(posedge mclk_i) disable iff (srst_i)
        (state_ff == ARB_IDLE && pick_valid) |=> grant_valid_ff && grant_id_ff == $past(pick_id))
        else $error("offered id differs from winner");
endmodule // msb_irq_arb

//--- msb_fw_model.sv
`timescale 1ns/1ps
module msb_fw_model (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o
);
    initial begin
        addr_o  = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 8'h00;
    end
    // one-cycle strobe, qualifiers held across the taking edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge mclk_i);
        wr_o    <= 1'b0;
        // released bus shows inverted data so stale values never match
        wdata_o <= ~d;
        addr_o  <= ~a;
    endtask
    // read data is registered, valid one cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge mclk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
endmodule // msb_fw_model

//--- tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, (e), (s)); end end
module tb;
    import msb_pkg::*;
    logic        mclk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [7:0]  addr, wdata, rdata, d, m0 = 8'h00;
    logic        wr, rd, req, txd, sck;
    logic        ack = 1'b0, reti = 1'b0;
    logic [23:0] ext = 24'h00_0000;
    logic [4:0]  id;
    logic [1:0]  bank;
    logic        rxd = 1'b1;
    logic [10:0] fr;
    int          lows;
    integer      seed = 32'h5900_8427;
    int          fails = 0, num_checks = 0;
    logic [7:0]  adrs [13] = '{ADR_SERIAL_CONTROL, ADR_BAUD_HIGH, ADR_BAUD_LOW, ADR_SYNC_DIV, ADR_PORT_TWO,
        ADR_IRQ_ENABLE, ADR_PORT3_MASK, ADR_IRQ_PRIO, ADR_STATUS_WORD, ADR_MAIN_OPERAND, ADR_MULDIV,
        ADR_PORT0_FLAGS, 8'h85};
    // done flags ignore written ones, so they drop out of the readback mask
    logic [7:0]  msks [13] = '{8'hDC, 8'hFF, 8'hFF, DIV_MASK, 8'hFF, IE_MASK, 8'hFF, IP_MASK, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h00};
    always #2.5 mclk_i = ~mclk_i;
    msb_fw_model fw (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    msb_sfr_bank dut (.mclk_i(mclk_i), .srst_i(srst_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .std_irq_flag_i(4'h0), .ext_irq_pulse_i(ext),
        .port0_irq_mask_i(m0), .port1_irq_mask_i(8'h00), .irq_ack_i(ack), .irq_reti_i(reti),
        .irq_req_o(req), .irq_id_o(id), .rxd_i(rxd), .txd_o(txd), .shift_clk_o(sck), .reg_bank_o(bank));
    function automatic logic [7:0] exp_rd(input logic [7:0] v, input logic [7:0] m);
        return v & m;
    endfunction
    task automatic results();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic pulse(input int b);
        @(posedge mclk_i) ext <= 24'h00_0001 << b;
        @(posedge mclk_i) ext <= 24'h00_0000;
    endtask
    // one bit per clock at reload zero; start bit held two edges to cover detection
    task automatic send_rx(input logic [7:0] b);
        fr = {1'b1, b, 2'b00};
        for (int k = 0; k < 11; k++) @(posedge mclk_i) rxd <= fr[k];
    endtask
    task automatic strobe_ack(input logic r);
        @(posedge mclk_i);
        if (r) reti <= 1'b1;
        else ack <= 1'b1;
        @(posedge mclk_i);
        ack  <= 1'b0;
        reti <= 1'b0;
    endtask
    task automatic irq_case(input logic pend, input int b);
        logic [7:0] v;
        fw.wr_reg(ADR_IRQ_ENABLE, {1'b1, pend, 6'h00});
        pulse(b);
        for (int i = 0; i < 20 && req !== 1'b1; i++) @(posedge mclk_i) #1;
        `CHK("irq_req", 1'b1, req)
        `CHK("irq_id", 5'(5 + b), id)
        strobe_ack(1'b0);
        fw.rd_reg(ADR_PORT0_FLAGS, v);
        `CHK("flag_after_ack", (pend ? (8'h01 << b) : 8'h00), v)
        `CHK("req_in_service", 1'b0, req)
        strobe_ack(1'b1);
        fw.rd_reg(ADR_PORT0_FLAGS, v);
        `CHK("flag_after_reti", 8'h00, v)
    endtask
    initial begin
        #100000;
        fails++;
        results();
    end
    initial begin
        logic [7:0] v;
        repeat (8) @(posedge mclk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            fw.rd_reg(adrs[i], v);
            `CHK("reset_val", ((i == 0) ? SC_RESET : REG_RESET), v)
        end
        // all-ones and all-zeros corners first, then random patterns
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 13; i++) begin
                d = (r == 0) ? 8'hFF : ((r == 1) ? 8'h00 : 8'($random(seed)));
                fw.wr_reg(adrs[i], d);
                fw.rd_reg(adrs[i], v);
                `CHK("readback", exp_rd(d, msks[i]), v)
                if (i == 8) `CHK("reg_bank", d[4:3], bank)
            end
        end
        fw.wr_reg(ADR_PORT0_FLAGS, 8'h00);
        @(posedge mclk_i) m0 <= 8'hFF;
        irq_case(1'b0, $unsigned($random(seed)) % 8);
        irq_case(1'b1, 7);
        fw.wr_reg(ADR_IRQ_ENABLE, 8'h40);
        pulse(3);
        repeat (5) @(posedge mclk_i);
        `CHK("req_global_off", 1'b0, req)
        fw.rd_reg(ADR_PORT0_FLAGS, v);
        `CHK("flag_set", 8'h08, v)
        fw.wr_reg(ADR_BAUD_HIGH, 8'h00);
        fw.wr_reg(ADR_BAUD_LOW, 8'h00);
        fw.wr_reg(ADR_SERIAL_CONTROL, 8'h40);
        send_rx(8'hA5);
        fw.rd_reg(ADR_SERIAL_CONTROL, v);
        `CHK("rx_gated", 8'h40, v)
        fw.wr_reg(ADR_SERIAL_CONTROL, SC_RESET);
        d = 8'($random(seed));
        send_rx(d);
        fw.rd_reg(ADR_SERIAL_DATA, v);
        `CHK("rx_data", d, v)
        fw.rd_reg(ADR_SERIAL_CONTROL, v);
        `CHK("rx_flags", 8'h55, v)
        fw.wr_reg(ADR_SERIAL_CONTROL, 8'h88);
        d = 8'($random(seed));
        fw.wr_reg(ADR_SERIAL_DATA, d);
        for (int k = 0; k < 11; k++) begin
            @(posedge mclk_i) #1;
            fr[k] = txd;
        end
        `CHK("tx_frame", {2'b11, d, 1'b0}, fr)
        fw.rd_reg(ADR_SERIAL_CONTROL, v);
        `CHK("tx_done", 8'h8A, v)
        fw.wr_reg(ADR_SYNC_DIV, 8'h00);
        fw.wr_reg(ADR_SERIAL_CONTROL, 8'h00);
        fw.wr_reg(ADR_SERIAL_DATA, d);
        lows = 0;
        // free-running divider phase may add one low cycle before the first bit
        repeat (24) begin
            @(posedge mclk_i) #1;
            lows += (sck == 1'b0);
        end
        `CHK("sck_pulses", 1'b1, (lows == 8 || lows == 9))
        results();
    end
endmodule // tb
